// file: include/sqs_pkg.sv
/*
 * shared constants and types for the sequencer stack slots block.
 * assumes a 32-bit axi4-lite register bus and a conversion-done strobe
 * from converter logic on the same clock.
 */
package sqs_pkg;

    typedef struct packed {
        logic       dir;
        logic [5:0] reg_addr;
        logic       return_flag;
        logic [3:0] ch_b;
        logic [3:0] ch_a;
    } sqs_slot_t;

    typedef struct packed {
        logic [3:0] ch_b;
        logic [3:0] ch_a;
    } sqs_pair_t;

    localparam logic [5:0] SQS_SLOT_BASE_INDEX = 6'h20;
    localparam logic [7:0] SQS_SLOT4_INDEX = 8'h24;
    localparam logic [7:0] SQS_SLOT5_INDEX = 8'h25;
    localparam logic [7:0] SQS_CTRL_INDEX = 8'h30;
    localparam logic [7:0] SQS_STAT_INDEX = 8'h31;
    localparam logic [15:0] SQS_SLOT4_RESET = 16'h4844;
    localparam logic [15:0] SQS_SLOT5_RESET = 16'h4a55;
    localparam int SQS_WRAP_SLOT = 7;
    localparam int SQS_CTRL_ENABLE_BIT = 0;
    localparam logic [1:0] SQS_RESP_OKAY = 2'h0;
    localparam logic [1:0] SQS_RESP_SLVERR = 2'h2;

    // reset word of slot k: read direction, own address, k in both fields
    function automatic sqs_slot_t sqs_reset_word(input int k);
        sqs_slot_t w;
        w.dir = 1'b0;
        w.reg_addr = SQS_SLOT_BASE_INDEX + 6'(k);
        w.return_flag = (k == SQS_WRAP_SLOT);
        w.ch_b = 4'(k);
        w.ch_a = 4'(k);
        return w;
    endfunction

endpackage

// file: core/sqs_slot.sv
/*
 * one sequencer stack slot word.
 * assumes the caller has already merged byte strobes into wr_word.
 */
module sqs_slot import sqs_pkg::*; #(
    parameter int INDEX = 0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_en,
    input wire sqs_slot_t wr_word,
    output sqs_slot_t word
);
    localparam sqs_slot_t RESET_WORD = sqs_reset_word(INDEX);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word <= RESET_WORD;
        end else if (wr_en && wr_word.reg_addr == RESET_WORD.reg_addr) begin
            if (wr_word.dir) begin
                word <= wr_word;
            end else begin
                // read access only marks direction; fields keep their value
                word.dir <= 1'b0;
            end
        end
    end
endmodule

// file: core/sqs_stack.sv
/*
 * sequencer stack with axi4-lite register access.
 * assumes conversion_done is a one-cycle pulse from converter logic
 * clocked by aclk; no synchroniser is needed for it.
 */
// The AXI4-Lite slave port was left to the implementer.
module sqs_stack import sqs_pkg::*; #(
    parameter int NUM_SLOTS = 8,
    parameter int ADDR_WIDTH = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic conversion_done,
    output logic [3:0] adc_a_channel_select,
    output logic [3:0] adc_b_channel_select
);
    localparam int SW = $clog2(NUM_SLOTS);
    localparam logic [SW-1:0] LAST_SLOT = SW'(NUM_SLOTS - 1);

    // slots beyond sixteen would land on the control and status indices
    if (NUM_SLOTS < 8 || NUM_SLOTS > 16 || ADDR_WIDTH < 10) begin : gen_bad
        $error("sqs_stack: unsupported NUM_SLOTS or ADDR_WIDTH");
    end

    sqs_slot_t slot_q [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] slot_wr;
    sqs_slot_t merged_word;
    sqs_slot_t target_word;
    sqs_slot_t cur_word;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_mapped;
    logic seq_enable;
    logic [SW-1:0] active_slot;
    logic [7:0] ar_idx;
    logic [31:0] next_rdata;
    logic rd_mapped;

    // write path: address and data are caught independently
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx <= s_axi_awaddr[9:2];
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_comb begin
        target_word = '0;
        wr_mapped = (aw_idx == SQS_CTRL_INDEX) || (aw_idx == SQS_STAT_INDEX);
        for (int k = 0; k < NUM_SLOTS; k++) begin
            slot_wr[k] = do_write && aw_idx == {2'h0, SQS_SLOT_BASE_INDEX}
                + 8'(k);
            if (aw_idx == {2'h0, SQS_SLOT_BASE_INDEX} + 8'(k)) begin
                target_word = slot_q[k];
                wr_mapped = 1'b1;
            end
        end
        merged_word = target_word;
        if (w_strb[0]) begin
            merged_word[7:0] = w_data[7:0];
        end
        if (w_strb[1]) begin
            merged_word[15:8] = w_data[15:8];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : gen_slot
            sqs_slot #(.INDEX(g)) u_slot (
                .aclk(aclk),
                .aresetn(aresetn),
                .wr_en(slot_wr[g]),
                .wr_word(merged_word),
                .word(slot_q[g])
            );
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_enable <= 1'b0;
        end else if (do_write && aw_idx == SQS_CTRL_INDEX && w_strb[0]) begin
            seq_enable <= w_data[SQS_CTRL_ENABLE_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SQS_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? SQS_RESP_OKAY : SQS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read path: one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_idx = s_axi_araddr[9:2];

    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_mapped = 1'b1;
        if (ar_idx == SQS_CTRL_INDEX) begin
            next_rdata[SQS_CTRL_ENABLE_BIT] = seq_enable;
        end else if (ar_idx == SQS_STAT_INDEX) begin
            next_rdata[SW-1:0] = active_slot;
        end else begin
            rd_mapped = 1'b0;
            for (int k = 0; k < NUM_SLOTS; k++) begin
                if (ar_idx == {2'h0, SQS_SLOT_BASE_INDEX} + 8'(k)) begin
                    next_rdata[15:0] = slot_q[k];
                    rd_mapped = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SQS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= rd_mapped ? SQS_RESP_OKAY : SQS_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // sequencer: parked on the first slot while disabled
    assign cur_word = slot_q[active_slot];

    always_ff @(posedge aclk) begin
        if (!aresetn || !seq_enable) begin
            active_slot <= '0;
        end else if (conversion_done) begin
            if (cur_word.return_flag || active_slot == LAST_SLOT) begin
                active_slot <= '0;
            end else begin
                active_slot <= active_slot + 1'b1;
            end
        end
    end

    // registered so a channel never glitches mid-conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adc_a_channel_select <= 4'h0;
            adc_b_channel_select <= 4'h0;
        end else begin
            adc_a_channel_select <= cur_word.ch_a;
            adc_b_channel_select <= cur_word.ch_b;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_step_next: assert property (
        seq_enable && conversion_done && !cur_word.return_flag
            && active_slot != LAST_SLOT
        |=> active_slot == $past(active_slot) + 1'b1 || !seq_enable)
        else $error("sequencer did not step to next slot");

    a_return_first: assert property (
        seq_enable && conversion_done && cur_word.return_flag
        |=> active_slot == '0)
        else $error("sequencer did not return to first slot");

    a_chan_b_follow: assert property (
        seq_enable && conversion_done && cur_word.return_flag
            && !slot_wr[0]
        |=> ##1 adc_b_channel_select == $past(slot_q[0].ch_b, 2))
        else $error("adc b channel not taken from first slot");

    a_chan_a_follow: assert property (
        $changed(active_slot) |=> adc_a_channel_select
            == $past(slot_q[active_slot].ch_a))
        else $error("adc a channel not taken from active slot");

    a_read_dir_keep: assert property (
        slot_wr[4] && !merged_word.dir
            && merged_word.reg_addr == 6'(SQS_SLOT4_INDEX)
        |=> slot_q[4][14:0] == $past(slot_q[4][14:0]) && !slot_q[4].dir)
        else $error("read direction write changed slot fields");

    a_addr_mismatch: assert property (
        slot_wr[5] && merged_word.reg_addr != 6'(SQS_SLOT5_INDEX)
        |=> slot_q[5] == $past(slot_q[5]))
        else $error("slot changed by write with foreign address");

    a_slot4_reset: assert property (
        $past(!aresetn) |-> slot_q[4] == SQS_SLOT4_RESET)
        else $error("slot 4 reset value wrong");

    a_slot5_reset: assert property (
        $past(!aresetn) |-> slot_q[5] == SQS_SLOT5_RESET)
        else $error("slot 5 reset value wrong");

    a_slot7_wrap: assert property (
        $past(!aresetn) |-> slot_q[SQS_WRAP_SLOT].return_flag)
        else $error("slot 7 return flag not set at reset");

    a_pair_apply: assert property (
        !$changed(active_slot) && !$past(slot_wr[active_slot])
        |-> {adc_b_channel_select, adc_a_channel_select}
            == {cur_word.ch_b, cur_word.ch_a})
        else $error("output channel pair differs from active slot");

    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    a_slot4_store: assert property (
        slot_wr[4] && merged_word.dir
            && merged_word.reg_addr == 6'(SQS_SLOT4_INDEX)
        |=> slot_q[4] == $past(merged_word))
        else $error("slot 4 write access not stored");

    a_slot5_store: assert property (
        slot_wr[5] && merged_word.dir
            && merged_word.reg_addr == 6'(SQS_SLOT5_INDEX)
        |=> slot_q[5] == $past(merged_word))
        else $error("slot 5 write with own address not stored");

    a_wrap_last: assert property (
        seq_enable && conversion_done && active_slot == LAST_SLOT
        |=> active_slot == '0)
        else $error("sequencer did not wrap after last slot");

    a_hold_idle: assert property (
        seq_enable && !conversion_done |=> $stable(active_slot))
        else $error("active slot moved without a conversion");

    a_park_off: assert property (
        !seq_enable |=> active_slot == '0)
        else $error("active slot not parked while disabled");

    a_chan_b_step: assert property (
        $changed(active_slot) |=> adc_b_channel_select
            == $past(slot_q[active_slot].ch_b))
        else $error("adc b channel not taken from active slot");

    a_unmapped_read: assert property (
        s_axi_arvalid && s_axi_arready && !rd_mapped
        |=> s_axi_rresp == SQS_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    a_write_answer: assert property (
        do_write |=> s_axi_bvalid)
        else $error("write committed without response");
endmodule

// file: tb/sqs_conv_model.sv
/*
 * converter model: raises a one-cycle conversion-done pulse every gap+1
 * cycles while run is high.
 * assumes the same clock and synchronous reset as the sequencer stack.
 */
module sqs_conv_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [3:0] gap,
    output logic conversion_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;

    // gap of zero gives back-to-back pulses, the hardest spacing
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt <= 0;
            conversion_done <= 1'b0;
        end else if (cnt >= int'(gap)) begin
            cnt <= 0;
            conversion_done <= 1'b1;
        end else begin
            cnt <= cnt + 1;
            conversion_done <= 1'b0;
        end
    end
endmodule

// file: tb/sqs_stack_tb.sv
/*
 * self-checking bench for the sequencer stack: axi4-lite host tasks,
 * converter model and a behavioural reference of slots and sequencer.
 * assumes the default of eight slots at byte address 0x80 + 4*k.
 */
module sqs_stack_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0;
    logic aresetn = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0, gap = '0;
    logic run = 0;
    logic awready, wready, bvalid, arready, rvalid, done;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [3:0] cha, chb;
    logic [15:0] mw [8];
    logic [7:0] exp_ch = '0;
    logic [3:0] wmask = 4'hf;
    int act, en, chk_on, err_count, checks_done, cyc;

    always #20 aclk = ~aclk;

    sqs_stack i_sqs_stack (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .conversion_done(done), .adc_a_channel_select(cha),
        .adc_b_channel_select(chb));

    sqs_conv_model i_sqs_conv_model (.aclk(aclk), .aresetn(aresetn),
        .run(run), .gap(gap), .conversion_done(done));

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic close_out;
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reference updated before the bus cycle; channels unchecked meanwhile
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        int k;
        logic aw, w;
        logic [1:0] e;
        logic [15:0] md;
        k = int'(a >> 2) - 32;
        e = 2'h2;
        if (k >= 0 && k < 8) begin
            e = 2'h0;
            md = mw[k];
            if (wmask[0]) md[7:0] = d[7:0];
            if (wmask[1]) md[15:8] = d[15:8];
            if (md[14:9] == 6'(32 + k)) begin
                if (md[15]) mw[k] = md;
                else mw[k][15] = 1'b0;
            end
        end
        if (a == 12'hc0) begin
            e = 2'h0;
            if (wmask[0]) en = int'(d[0]);
        end
        if (a == 12'hc4) e = 2'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= wmask;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 0;
        w = 0;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awready && !aw) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wready && !w) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", 32'(e), 32'(bresp));
        bready <= 1'b0;
    endtask

    task automatic reg_rd(input logic [11:0] a);
        int k;
        logic [31:0] e;
        logic [1:0] r;
        k = int'(a >> 2) - 32;
        e = '0;
        r = 2'h2;
        if (k >= 0 && k < 8) begin
            e = 32'(mw[k]);
            r = 2'h0;
        end
        if (a == 12'hc0 || a == 12'hc4) begin
            e = (a == 12'hc0) ? 32'(en) : 32'(act);
            r = 2'h0;
        end
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        chk("rdata", e, rdata);
        chk("rresp", 32'(r), 32'(rresp));
        rready <= 1'b0;
    endtask

    // outputs compared before this edge's updates land
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 5000) begin
            err_count++;
            close_out();
        end
        if (chk_on != 0) chk("channels", 32'(exp_ch), 32'({chb, cha}));
        exp_ch = mw[act][7:0];
        // a disabled sequencer sits on the first slot
        if (!aresetn || en == 0) begin
            act = 0;
        end else if (done === 1'b1) begin
            act = (mw[act][8] || act == 7) ? 0 : act + 1;
        end
    end

    task automatic seq_run(input int n, input logic [3:0] g);
        gap <= g;
        // let a just-written enable settle the active slot first
        repeat (2) @(posedge aclk);
        chk_on <= 1;
        run <= 1'b1;
        repeat (n) @(posedge aclk);
        run <= 1'b0;
        repeat (3) @(posedge aclk);
        chk_on <= 0;
        reg_rd(12'hc4);
    endtask

    initial begin
        int s;
        logic [31:0] d;
        void'($urandom(52770));
        for (int k = 0; k < 8; k++) begin
            mw[k] = 16'(((32 + k) << 9) | ((k == 7) << 8) | (k << 4) | k);
        end
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 8; k++) reg_rd(12'(128 + 4 * k));
        reg_rd(12'hc0);
        reg_rd(12'h3fc);
        reg_wr(12'h3fc, 32'hffffffff);
        for (int i = 0; i < 6; i++) begin
            s = 4 + i % 2;
            d = $urandom();
            d[15] = (i / 2 != 2);
            d[14:9] = 6'(32 + s + ((i / 2 == 1) ? 1 : 0));
            d[8] = 1'b0;
            reg_wr(12'(4 * (32 + s)), d);
            reg_rd(12'(4 * (32 + s)));
        end
        d = $urandom();
        wmask = 4'h2;
        reg_wr(12'h90, {16'h0, 1'b1, 6'h24, 1'b0, d[7:0]});
        wmask = 4'h1;
        reg_wr(12'h90, d);
        wmask = 4'hf;
        reg_rd(12'h90);
        d = $urandom();
        reg_wr(12'h94, {d[31:16], 1'b1, 6'h25, 1'b1, d[7:0]});
        reg_wr(12'hc0, 32'h1);
        seq_run(60, 4'($urandom_range(3)));
        reg_wr(12'h94, {d[31:16], 1'b1, 6'h25, 1'b0, d[7:0]});
        seq_run(40, 4'h0);
        reg_wr(12'hc0, 32'h0);
        seq_run(12, 4'h0);
        reg_rd(12'hc0);
        close_out();
    end
endmodule
